// ===== rtl/mifm_defs.svh
// Constants of the maskable interrupt flag matrix: offsets, bit positions, reset values.
`ifndef MIFM_DEFS_SVH
`define MIFM_DEFS_SVH

// Register offsets; bits [1:0] of a flag register select the byte.
`define MIFM_ADDR_REQ_BASE  5'h00
`define MIFM_ADDR_MASK_BASE 5'h04
`define MIFM_ADDR_PR0_BASE  5'h08
`define MIFM_ADDR_PR1_BASE  5'h0C
`define MIFM_ADDR_EGP       5'h10
`define MIFM_ADDR_EGN       5'h11

// Flag bit positions across the four bytes (grp0 lo, grp0 hi, grp1 lo, grp1 hi).
`define MIFM_BIT_SHARED_TX  7
`define MIFM_BIT_SHARED_RX  8
`define MIFM_BIT_EXT_PIN6   14
`define MIFM_BIT_EXT_PIN7   15
`define MIFM_SRC_NUM        27

// Reset values.
`define MIFM_REQ_RST        1'b0
`define MIFM_MASK_RST       1'b1
`define MIFM_PRIO_RST       1'b1
`define MIFM_EDGE_RST       8'h00

`endif

// ===== rtl/mifm_pkg.sv
// Types shared by the maskable interrupt flag matrix.
package mifm_pkg;
    typedef logic [4:0] mifm_src_id_t;
    typedef logic [1:0] mifm_level_t;
    typedef logic [7:0] mifm_byte_t;
    typedef logic [4:0] mifm_addr_t;
endpackage

// ===== rtl/mifm_flag_slice.sv
// One interrupt source: request flag, mask flag and two priority bits.
`timescale 1ns/1ps
`include "mifm_defs.svh"
module mifm_flag_slice #(
    parameter bit AVAIL = 1'b1
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       setReq,
    input  wire logic       ackClr,
    input  wire logic [3:0] wrKind,
    input  wire logic       wrVal,
    output logic            reqFlag,
    output logic            maskFlag,
    output logic            prioLo,
    output logic            prioHi
);
    // Request flag: a hardware set beats both acknowledge and software clear,
    // so an event landing on the clearing cycle is never lost.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reqFlag <= `MIFM_REQ_RST;
        end else if (AVAIL) begin
            if (setReq) begin
                reqFlag <= 1'b1;
            end else if (ackClr) begin
                reqFlag <= 1'b0;
            end else if (wrKind[0]) begin
                reqFlag <= wrVal;
            end
        end
    end

    // Mask and priority bits; unavailable bits stay at their reset value.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            maskFlag <= `MIFM_MASK_RST;
            prioLo   <= `MIFM_PRIO_RST;
            prioHi   <= `MIFM_PRIO_RST;
        end else if (AVAIL) begin
            if (wrKind[1]) begin
                maskFlag <= wrVal;
            end
            if (wrKind[2]) begin
                prioLo <= wrVal;
            end
            if (wrKind[3]) begin
                prioHi <= wrVal;
            end
        end
    end
endmodule

// ===== rtl/mifm_top.sv
// Maskable interrupt flag matrix: flag banks, acceptance and default-order arbitration.
`timescale 1ns/1ps
`include "mifm_defs.svh"
module mifm_top
    import mifm_pkg::*;
#(
    parameter int EXT_PIN_NUM = 8
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         wdtIrq,
    input  wire logic [7:0]   extPinIrq,
    input  wire logic         serial0TxEndIrq,
    input  wire logic         clockedSerial00Irq,
    input  wire logic         twowire00Irq,
    input  wire logic         serial0RxEndIrq,
    input  wire logic         clockedSerial01Irq,
    input  wire logic         twowire01Irq,
    input  wire logic         serialErrIrq,
    input  wire logic         timer1UpperIrq,
    input  wire logic         timer0Irq,
    input  wire logic         timer1Irq,
    input  wire logic         adcIrq,
    input  wire logic         timer3UpperIrq,
    input  wire logic         dedicatedTwowireIrq,
    input  wire logic         timer2Irq,
    input  wire logic         timer3Irq,
    input  wire logic         intervalTimerIrq,
    input  wire logic         timer4Irq,
    input  wire logic         timer5Irq,
    input  wire logic         timer6Irq,
    input  wire logic         timer7Irq,
    input  wire logic         comparator0Irq,
    input  wire logic         comparator1Irq,
    input  wire logic         globalIrqEnable,
    input  wire logic         inserviceLevelBit0,
    input  wire logic         inserviceLevelBit1,
    input  wire logic         ackValid,
    input  wire mifm_src_id_t ackId,
    input  wire logic         swWr,
    input  wire mifm_addr_t   swAddr,
    input  wire mifm_byte_t   swData,
    input  wire mifm_byte_t   swBitEn,
    output mifm_byte_t        rdData_r,
    output mifm_byte_t        extRiseEnable_r,
    output mifm_byte_t        extFallEnable_r,
    output logic              irqPending_r,
    output mifm_src_id_t      irqId_r,
    output mifm_level_t       irqLevel_r
);
    // Pins 6 and 7 are absent on the six-input variant.
    localparam mifm_byte_t PIN_MASK = (EXT_PIN_NUM == 6) ? 8'h3F : 8'hFF;

    logic [31:0]  rawSet;
    logic [31:0]  reqVec;
    logic [31:0]  maskVec;
    logic [31:0]  p0Vec;
    logic [31:0]  p1Vec;
    logic [31:0]  elig;
    logic         txShared;
    logic         rxShared;
    mifm_level_t  ispLevel;
    logic         winFound;
    mifm_src_id_t winId;
    mifm_level_t  winLevel;
    mifm_byte_t   rdData_nxt;

    // Three serial sources collapse onto one flag each side.
    assign txShared = serial0TxEndIrq | clockedSerial00Irq | twowire00Irq;
    assign rxShared = serial0RxEndIrq | clockedSerial01Irq | twowire01Irq;
    assign ispLevel = {inserviceLevelBit1, inserviceLevelBit0};

    // Source placement in the four flag bytes, top bits of group1 high unused.
    assign rawSet = {5'h00, comparator1Irq, comparator0Irq, timer7Irq,
                     timer6Irq, timer5Irq, timer4Irq, intervalTimerIrq,
                     timer3Irq, timer2Irq, dedicatedTwowireIrq, timer3UpperIrq,
                     extPinIrq[7], extPinIrq[6], adcIrq, timer1Irq,
                     timer0Irq, timer1UpperIrq, serialErrIrq, rxShared,
                     txShared, extPinIrq[5:0], wdtIrq};

    // One slice per flag bit; the shared bits carry a single mask and priority.
    for (genvar i = 0; i < 32; i++) begin : g_slice
        localparam bit AVAIL = (i < `MIFM_SRC_NUM) &&
            !((EXT_PIN_NUM == 6) && (i == `MIFM_BIT_EXT_PIN6 || i == `MIFM_BIT_EXT_PIN7));
        logic       bitHit;
        logic [3:0] wrKind;
        assign bitHit = swWr && !swAddr[4] && (swAddr[1:0] == 2'(i / 8)) && swBitEn[i % 8];
        assign wrKind = bitHit ? (4'h1 << swAddr[3:2]) : 4'h0;
        mifm_flag_slice #(
            .AVAIL (AVAIL)
        ) u_slice (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .setReq   (rawSet[i]),
            .ackClr   (ackValid && (ackId == 5'(i))),
            .wrKind   (wrKind),
            .wrVal    (swData[i % 8]),
            .reqFlag  (reqVec[i]),
            .maskFlag (maskVec[i]),
            .prioLo   (p0Vec[i]),
            .prioHi   (p1Vec[i])
        );
        // Level 0 is the most urgent; it must beat the in-service level outright.
        assign elig[i] = reqVec[i] && !maskVec[i] && globalIrqEnable &&
                         ({p1Vec[i], p0Vec[i]} < ispLevel);
    end

    // Most urgent level wins; ties go to the lower index, the fixed default order.
    always_comb begin
        winFound = 1'b0;
        winId    = 5'h00;
        winLevel = 2'h3;
        for (int i = 0; i < `MIFM_SRC_NUM; i++) begin
            if (elig[i] && (!winFound || {p1Vec[i], p0Vec[i]} < winLevel)) begin
                winFound = 1'b1;
                winId    = 5'(i);
                winLevel = {p1Vec[i], p0Vec[i]};
            end
        end
    end

    // Registered request to the core; one cycle behind the flags by design.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqPending_r <= 1'b0;
            irqId_r      <= 5'h00;
            irqLevel_r   <= 2'h3;
        end else begin
            irqPending_r <= winFound;
            irqId_r      <= winId;
            irqLevel_r   <= winLevel;
        end
    end

    // External edge enables, bit-writable; absent pins hold zero.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            extRiseEnable_r <= `MIFM_EDGE_RST;
            extFallEnable_r <= `MIFM_EDGE_RST;
        end else if (swWr) begin
            if (swAddr == `MIFM_ADDR_EGP) begin
                extRiseEnable_r <= ((extRiseEnable_r & ~swBitEn) | (swData & swBitEn)) & PIN_MASK;
            end
            if (swAddr == `MIFM_ADDR_EGN) begin
                extFallEnable_r <= ((extFallEnable_r & ~swBitEn) | (swData & swBitEn)) & PIN_MASK;
            end
        end
    end

    // Read mux; unmapped offsets return zero.
    always_comb begin
        case (swAddr[4:2])
            3'h0:    rdData_nxt = reqVec[{swAddr[1:0], 3'b000} +: 8];
            3'h1:    rdData_nxt = maskVec[{swAddr[1:0], 3'b000} +: 8];
            3'h2:    rdData_nxt = p0Vec[{swAddr[1:0], 3'b000} +: 8];
            3'h3:    rdData_nxt = p1Vec[{swAddr[1:0], 3'b000} +: 8];
            3'h4: begin
                if (swAddr == `MIFM_ADDR_EGP) begin
                    rdData_nxt = extRiseEnable_r;
                end else if (swAddr == `MIFM_ADDR_EGN) begin
                    rdData_nxt = extFallEnable_r;
                end else begin
                    rdData_nxt = 8'h00;
                end
            end
            default: rdData_nxt = 8'h00;
        endcase
    end

    // Read data lands one cycle after the address.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_r <= 8'h00;
        end else begin
            rdData_r <= rdData_nxt;
        end
    end

    // Helper state for the checks below.
    // The mask copy lets the winner check index the mask with the current winner id.
    logic [31:0] eligPrev;
    logic [31:0] maskPrev;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            eligPrev <= 32'h0000_0000;
            maskPrev <= 32'hFFFF_FFFF;
        end else begin
            eligPrev <= elig;
            maskPrev <= maskVec;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_txEvent;
        serial0TxEndIrq || clockedSerial00Irq || twowire00Irq;
    endsequence
    sequence s_rxEvent;
        serial0RxEndIrq || clockedSerial01Irq || twowire01Irq;
    endsequence

    property p_txShared;
        s_txEvent |=> reqVec[`MIFM_BIT_SHARED_TX];
    endproperty
    a_txShared: assert property (p_txShared) else $error("tx flag not set");

    property p_rxShared;
        s_rxEvent |=> reqVec[`MIFM_BIT_SHARED_RX];
    endproperty
    a_rxShared: assert property (p_rxShared) else $error("rx flag not set");

    property p_ackClears;
        ackValid && !rawSet[ackId] |=> !reqVec[$past(ackId)];
    endproperty
    a_ackClears: assert property (p_ackClears) else $error("ack did not clear");

    property p_setWins;
        ackValid && rawSet[ackId] |=> reqVec[$past(ackId)];
    endproperty
    a_setWins: assert property (p_setWins) else $error("set lost to ack");

    property p_gieOff;
        !globalIrqEnable |=> !irqPending_r;
    endproperty
    a_gieOff: assert property (p_gieOff) else $error("presented while disabled");

    property p_aboveIsp;
        irqPending_r |-> irqLevel_r < $past(ispLevel);
    endproperty
    a_aboveIsp: assert property (p_aboveIsp) else $error("level not above in-service");

    property p_winnerEligible;
        irqPending_r |-> eligPrev[irqId_r] && !maskPrev[irqId_r];
    endproperty
    a_winnerEligible: assert property (p_winnerEligible) else $error("winner ineligible");

    property p_anyPresented;
        (elig != 32'h0000_0000) |=> irqPending_r;
    endproperty
    a_anyPresented: assert property (p_anyPresented) else $error("eligible not presented");

    property p_unusedZero;
        reqVec[31:`MIFM_SRC_NUM] == 5'h00 && maskVec[31:`MIFM_SRC_NUM] == 5'h1F;
    endproperty
    a_unusedZero: assert property (p_unusedZero) else $error("unused bits moved");

    property p_pinVariant;
        (EXT_PIN_NUM == 6) |-> reqVec[`MIFM_BIT_EXT_PIN7:`MIFM_BIT_EXT_PIN6] == 2'h0;
    endproperty
    a_pinVariant: assert property (p_pinVariant) else $error("absent pin flag set");
endmodule

// ===== testbench/mifm_cpu_model.sv
// CPU side model that acknowledges the presented interrupt, then pauses for a chosen delay before the next.
`timescale 1ns/1ps
module mifm_cpu_model
    import mifm_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         ackEnable,
    input  wire logic [2:0]   ackDelay,
    input  wire logic         irqPending_r,
    input  wire mifm_src_id_t irqId_r,
    output logic              ackValid,
    output mifm_src_id_t      ackId
);
    logic [3:0] waitCnt_r;
    // One pulse, then a pause, since the pending output lags the acknowledge by two edges.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ackValid  <= 1'b0;
            ackId     <= 5'h00;
            waitCnt_r <= 4'h0;
        end else begin
            ackValid <= 1'b0;
            ackId    <= ~ackId; // Idle id is junk, so nothing may rely on it.
            if (waitCnt_r != 4'h0) begin
                waitCnt_r <= waitCnt_r - 4'h1;
            end else if (ackEnable && irqPending_r) begin
                ackValid  <= 1'b1;
                ackId     <= irqId_r;
                waitCnt_r <= {1'b0, ackDelay} + 4'h2;
            end
        end
    end
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the interrupt flag matrix with a CPU acknowledge model.
`timescale 1ns/1ps
module tb
    import mifm_pkg::*;
;
    logic         core_clk = 1'b0;
    logic         rst_n = 1'b0;
    logic [26:0]  src = '0;
    logic [2:0]   txSrc = '0, rxSrc = '0, ackDelay = '0;
    logic         gie = 1'b0, ackEnable = 1'b0, swWr = 1'b0;
    logic [1:0]   isp = 2'h3;
    mifm_addr_t   swAddr = 5'h00;
    mifm_byte_t   swData = 8'h00, swBitEn = 8'h00;
    mifm_byte_t   rdData_r, extRiseEnable_r, extFallEnable_r;
    logic         irqPending_r, ackValid;
    mifm_src_id_t irqId_r, ackId;
    mifm_level_t  irqLevel_r;
    logic [6:0]   expQ[$];
    logic [31:0]  m, p0, p1, rq, left;
    int           n_errors = 0, compares = 0, seed = 32'hA062;
    int           i, k, r, b, w, lv;

    mifm_top #(.EXT_PIN_NUM(8)) u_mifm_top (
        .core_clk(core_clk), .rst_n(rst_n), .wdtIrq(src[0]),
        .extPinIrq({src[15:14], src[6:1]}),
        .serial0TxEndIrq(txSrc[0]), .clockedSerial00Irq(txSrc[1]), .twowire00Irq(txSrc[2]),
        .serial0RxEndIrq(rxSrc[0]), .clockedSerial01Irq(rxSrc[1]), .twowire01Irq(rxSrc[2]),
        .serialErrIrq(src[9]), .timer1UpperIrq(src[10]), .timer0Irq(src[11]),
        .timer1Irq(src[12]), .adcIrq(src[13]), .timer3UpperIrq(src[16]),
        .dedicatedTwowireIrq(src[17]), .timer2Irq(src[18]), .timer3Irq(src[19]),
        .intervalTimerIrq(src[20]), .timer4Irq(src[21]), .timer5Irq(src[22]),
        .timer6Irq(src[23]), .timer7Irq(src[24]), .comparator0Irq(src[25]),
        .comparator1Irq(src[26]), .globalIrqEnable(gie), .inserviceLevelBit0(isp[0]),
        .inserviceLevelBit1(isp[1]), .ackValid(ackValid), .ackId(ackId), .swWr(swWr),
        .swAddr(swAddr), .swData(swData), .swBitEn(swBitEn), .rdData_r(rdData_r),
        .extRiseEnable_r(extRiseEnable_r), .extFallEnable_r(extFallEnable_r),
        .irqPending_r(irqPending_r), .irqId_r(irqId_r), .irqLevel_r(irqLevel_r)
    );
    mifm_cpu_model u_mifm_cpu_model (
        .core_clk(core_clk), .rst_n(rst_n), .ackEnable(ackEnable), .ackDelay(ackDelay),
        .irqPending_r(irqPending_r), .irqId_r(irqId_r), .ackValid(ackValid), .ackId(ackId)
    );

    // Free-running 25 MHz clock.
    always #20 core_clk = ~core_clk;

    task automatic step;
        @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    // Byte write; the trailing idle cycle keeps back-to-back calls from racing on swWr.
    task automatic wr(input mifm_addr_t a, input mifm_byte_t d, input mifm_byte_t be);
        swWr = 1'b1;
        swAddr = a;
        swData = d;
        swBitEn = be;
        step;
        swWr = 1'b0;
        step;
    endtask
    task automatic rd(input mifm_addr_t a, input mifm_byte_t e, input string nm);
        swAddr = a;
        step;
        chk(nm, rdData_r, e);
    endtask
    task automatic close_out;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Each acknowledge is matched against the oldest expected winner and its level.
    always @(posedge core_clk) begin
        if (ackValid === 1'b1) begin
            if (expQ.size() == 0) begin
                chk("extraAck", 32'h1, 32'h0);
            end else begin
                chk("winner", {irqLevel_r, ackId}, expQ.pop_front());
            end
        end
    end

    // Main sequence: reset values, register access, per-source flags, random arbitration.
    initial begin
        repeat (8) @(posedge core_clk);
        #1 rst_n = 1'b1;
        for (i = 0; i < 19; i++) begin
            rd(5'(i), (i > 3 && i < 16) ? 8'hFF : 8'h00, "resetValue");
        end
        wr(5'h04, 8'h00, 8'h01);
        rd(5'h04, 8'hFE, "bitEnable");
        wr(5'h04, 8'hFF, 8'h01);
        wr(5'h10, 8'hA5, 8'hFF);
        wr(5'h11, 8'h5A, 8'hFF);
        wr(5'h12, 8'hFF, 8'hFF);
        chk("edgeRegs", {extRiseEnable_r, extFallEnable_r}, 16'hA55A);
        rd(5'h12, 8'h00, "unmapped");
        // Every source lands on its own flag; each member of a shared serial group lands on that group's shared flag.
        for (i = 0; i < 27; i++) begin
            for (k = 0; k < ((i == 7 || i == 8) ? 3 : 1); k++) begin
                if (i == 7) txSrc[k] = 1'b1;
                else if (i == 8) rxSrc[k] = 1'b1;
                else src[i] = 1'b1;
                step;
                src = '0;
                txSrc = '0;
                rxSrc = '0;
                rd(5'(i / 8), 8'h01 << (i % 8), "flagPos");
                wr(5'(i / 8), 8'h00, 8'h01 << (i % 8));
            end
        end
        for (r = 0; r < 10; r++) begin
            m = $random(seed);
            p0 = $random(seed);
            p1 = $random(seed);
            rq = $random(seed);
            isp = 2'($random(seed));
            ackDelay = 3'($random(seed));
            for (b = 0; b < 4; b++) begin
                wr(5'(4 + b), m[b*8+:8], 8'hFF);
                wr(5'(8 + b), p0[b*8+:8], 8'hFF);
                wr(5'(12 + b), p1[b*8+:8], 8'hFF);
            end
            left = rq & 32'h07FF_FFFF;
            for (lv = 0; lv < 3; lv++) begin
                for (i = 0; i < 27; i++) begin
                    if (rq[i] && !m[i] && {p1[i], p0[i]} == lv && lv < isp) begin
                        expQ.push_back({2'(lv), 5'(i)});
                        left[i] = 1'b0;
                    end
                end
            end
            src = rq[26:0];
            txSrc = {2'b00, rq[7]};
            rxSrc = {rq[8], 2'b00};
            step;
            src = '0;
            txSrc = '0;
            rxSrc = '0;
            repeat (2) step;
            chk("gieOff", irqPending_r, 1'b0);
            gie = 1'b1;
            ackEnable = 1'b1;
            for (w = 0; w < 300 && expQ.size() > 0; w++) step;
            repeat (6) step;
            chk("ackMissing", expQ.size(), 0);
            chk("pendingLeft", irqPending_r, 1'b0);
            expQ.delete();
            ackEnable = 1'b0;
            gie = 1'b0;
            for (b = 0; b < 4; b++) begin
                rd(5'(b), left[b*8+:8], "reqLeft");
                wr(5'(b), 8'h00, 8'hFF);
            end
        end
        // A source held high across an acknowledge keeps its flag, so two acks follow.
        wr(5'h04, 8'h00, 8'h01);
        wr(5'h08, 8'h00, 8'h01);
        wr(5'h0C, 8'h00, 8'h01);
        isp = 2'h3;
        ackDelay = 3'h0;
        expQ.push_back(7'h00);
        expQ.push_back(7'h00);
        gie = 1'b1;
        ackEnable = 1'b1;
        src[0] = 1'b1;
        repeat (6) step;
        src[0] = 1'b0;
        repeat (6) step;
        chk("setWinsAcks", expQ.size(), 0);
        chk("setWinsIdle", irqPending_r, 1'b0);
        rd(5'h00, 8'h00, "setWinsFlag");
        gie = 1'b0;
        ackEnable = 1'b0;
        close_out;
    end

    // About thirty times the expected run; a hang counts as a mismatch.
    initial begin
        #1000000;
        n_errors++;
        close_out;
    end
endmodule
